// ===== dv/pin_observer.sv
// far-side capture circuit on the timer output pin
`timescale 1ns/1ps
module pin_observer (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        pin,
	input  wire logic        sel,
	input  wire logic        mark,
	output logic      [31:0] marks_q,
	output logic      [31:0] highs_q,
	output logic      [31:0] per_q,
	output logic      [31:0] hper_q
);
	logic [31:0] len_q;
	logic [31:0] hi_q;
	wire         level = sel & pin; // pulled low while not selected

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{marks_q, highs_q, per_q, hper_q, len_q, hi_q} <= '0;
		end else begin
			highs_q <= highs_q + 32'(level);
			if (mark) begin
				marks_q <= marks_q + 32'h1;
				per_q   <= len_q;
				hper_q  <= hi_q;
				len_q   <= 32'h1;
				hi_q    <= 32'(level);
			end else begin
				len_q <= len_q + 32'h1;
				hi_q  <= hi_q + 32'(level);
			end
		end
	end
endmodule : pin_observer

// ===== dv/timer_oneshot_pwm_tb_top.sv
// self-checking bench for the one-shot and pwm timer
`timescale 1ns/1ps
`include "timer_regs.svh"
module timer_oneshot_pwm_tb_top;
	import timer_pkg::*;
	logic        core_clk      = 1'b0;
	logic        rst           = 1'b1;
	logic [4:0]  avs_address   = '0;
	logic        avs_read      = 1'b0;
	logic        avs_write     = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        tmr_out;
	logic        tmr_out_sel;
	logic        irq_pulse;
	logic        irq;
	logic [31:0] marks, highs, per, hper, q;
	int          failures      = 0;
	int          cmp_count     = 0;
	int          rl, mt, p, m0, h0, n;

	initial begin
		forever #2.5 core_clk = ~core_clk;
	end

	timer_oneshot_pwm u_dut (.CORE_CLK(core_clk), .RST(rst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
		.AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hf),
		.AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .TMR_OUT(tmr_out),
		.TMR_OUT_SEL(tmr_out_sel), .TIMER_IRQ_PULSE(irq_pulse), .IRQ(irq));

	pin_observer u_obs (.clk(core_clk), .rst(rst), .pin(tmr_out), .sel(tmr_out_sel), .mark(irq_pulse),
		.marks_q(marks), .highs_q(highs), .per_q(per), .hper_q(hper));

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out

	task automatic cmp(input string k, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s at %0t got %h exp %h", k, $time, got, exp);
		end
	endtask : cmp

	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address   <= a;
		avs_write     <= wr;
		avs_read      <= ~wr;
		avs_writedata <= d;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge core_clk);
		end
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic chk_reg(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, '0);
		cmp("reg", q, exp);
	endtask : chk_reg

	task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
		cmp("pin", got, exp);
	endtask : chk_pin

	task automatic wait_marks(input int target);
		while (int'(marks) < target) begin
			@(posedge core_clk);
		end
	endtask : wait_marks

	function automatic logic [31:0] ctl(input logic en, input tmode_e md, input int pr, input logic pol,
		input logic alt);
		return {25'h0, alt, pol, 3'(pr), 1'(md), en};
	endfunction : ctl

	initial begin
		void'($urandom(32'hbcc8));
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		// reset values, last offset unmapped
		for (int i = 0; i <= 6; i++) begin
			chk_reg(5'(4 * i), '0);
		end
		// one-shot, pin selected, polarity low
		wr(`TMR_OFF_CTRL, ctl(0, TMODE_ONESHOT, 1, 0, 1));
		wr(`TMR_OFF_COUNT, 32'h1);
		wr(`TMR_OFF_RELOAD, 32'h3);
		m0 = int'(marks);
		h0 = int'(highs);
		wr(`TMR_OFF_CTRL, ctl(1, TMODE_ONESHOT, 1, 0, 1));
		wait_marks(m0 + 1);
		repeat (40) @(posedge core_clk);
		chk_pin(marks - m0, 1);
		chk_pin(highs - h0, 1);
		chk_reg(`TMR_OFF_COUNT, 32'h1);
		chk_reg(`TMR_OFF_CTRL, ctl(0, TMODE_ONESHOT, 1, 0, 1));
		chk_reg(`TMR_OFF_STATUS, 32'h1);
		chk_pin({31'h0, irq}, 0);
		wr(`TMR_OFF_MASK, 32'h1);
		@(negedge core_clk);
		chk_pin({31'h0, irq}, 1);
		wr(`TMR_OFF_STATUS, 32'h1);
		@(negedge core_clk);
		chk_pin({31'h0, irq}, 0);
		chk_reg(`TMR_OFF_STATUS, 32'h0);
		// count through all-ones, reload zero and two
		for (int r = 0; r <= 2; r += 2) begin
			wr(`TMR_OFF_CTRL, ctl(0, TMODE_ONESHOT, 0, 0, 0));
			wr(`TMR_OFF_COUNT, 32'hfffe);
			wr(`TMR_OFF_RELOAD, 32'(r));
			m0 = int'(marks);
			wr(`TMR_OFF_CTRL, ctl(1, TMODE_ONESHOT, 0, 0, 0));
			wait_marks(m0 + 1);
			chk_pin(marks - m0, 1);
			chk_reg(`TMR_OFF_COUNT, 32'h1);
			chk_pin({31'h0, tmr_out_sel}, 0);
		end
		// pwm over every prescale, both polarities
		for (p = 0; p < 8; p++) begin
			rl = 3 + $urandom % 20;
			mt = 1 + $urandom % (rl - 1);
			wr(`TMR_OFF_CTRL, ctl(0, TMODE_PWM, p, p[0], 1));
			wr(`TMR_OFF_COUNT, 32'(1 + $urandom % rl));
			wr(`TMR_OFF_MATCH, 32'(mt));
			wr(`TMR_OFF_RELOAD, 32'(rl));
			m0 = int'(marks);
			wr(`TMR_OFF_CTRL, ctl(1, TMODE_PWM, p, p[0], 1));
			wait_marks(m0 + 3);
			n = (rl - mt) << p;
			chk_pin(per, rl << p);
			chk_pin(hper, p[0] ? (rl << p) - n : n);
			chk_reg(`TMR_OFF_STATUS, 32'h3);
			wr(`TMR_OFF_STATUS, 32'h3);
		end
		close_out();
	end

	initial begin
		repeat (90000) @(posedge core_clk);
		failures++;
		close_out();
	end
endmodule : timer_oneshot_pwm_tb_top

// ===== src/tick_divider.sv
// power-of-two prescaler producing count ticks
`timescale 1ns/1ps
module tick_divider (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       run,
	input  wire logic [2:0] div_sel,
	output logic            tick
);

	logic [6:0] cnt_q;
	logic [6:0] cnt_d;
	logic [7:0] span;
	logic [6:0] low_mask;

	// low_mask has div_sel ones, so a tick every 2**div_sel cycles
	assign span     = 8'h01 << div_sel;
	assign low_mask = 7'(span - 8'h01);
	assign tick     = run & ((cnt_q | ~low_mask) == 7'h7f);
	assign cnt_d    = (!run || tick) ? 7'h00 : 7'(cnt_q + 7'h01);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 7'h00;
		end else begin
			cnt_q <= cnt_d;
		end
	end

endmodule : tick_divider

// ===== src/timer_oneshot_pwm.sv
// 16-bit one-shot / single-output pwm timer with avalon-mm registers
`timescale 1ns/1ps
`include "timer_regs.svh"
module timer_oneshot_pwm
	import timer_pkg::*;
(
	input  wire logic                   CORE_CLK,
	input  wire logic                   RST,
	input  wire logic [`TMR_ADDR_W-1:0] AVS_ADDRESS,
	input  wire logic                   AVS_READ,
	input  wire logic                   AVS_WRITE,
	input  wire logic [31:0]            AVS_WRITEDATA,
	input  wire logic [3:0]             AVS_BYTEENABLE,
	output logic      [31:0]            AVS_READDATA,
	output logic                        AVS_WAITREQUEST,
	output logic                        TMR_OUT,
	output logic                        TMR_OUT_SEL,
	output logic                        TIMER_IRQ_PULSE,
	output logic                        IRQ
);

	logic                     ack_q;
	logic [31:0]              rdata_q;
	logic [`TMR_CTRL_W-1:0]   ctrl_q;
	logic [`TMR_CTRL_W-1:0]   ctrl_d;
	count_t                   count_q;
	count_t                   count_d;
	count_t                   match_q;
	count_t                   reload_q;
	logic [`TMR_ST_W-1:0]     status_q;
	logic [`TMR_ST_W-1:0]     status_d;
	logic [`TMR_ST_W-1:0]     mask_q;
	logic                     level_q;
	logic                     level_d;
	logic                     out_q;
	logic                     out_d;
	logic                     pulse_q;
	logic                     tick;

	function automatic count_t merge16(count_t old, logic [31:0] wd, logic [3:0] be);
		count_t r;
		r = old;
		if (be[0]) r[7:0] = wd[7:0];
		if (be[1]) r[15:8] = wd[15:8];
		return r;
	endfunction : merge16

	// bus decode: one wait state, read data registered
	wire req       = AVS_READ | AVS_WRITE;
	wire wr_fire   = AVS_WRITE & ack_q;
	wire sel_ctrl  = AVS_ADDRESS == `TMR_OFF_CTRL;
	wire sel_count = AVS_ADDRESS == `TMR_OFF_COUNT;
	wire sel_match = AVS_ADDRESS == `TMR_OFF_MATCH;
	wire sel_rld   = AVS_ADDRESS == `TMR_OFF_RELOAD;
	wire sel_stat  = AVS_ADDRESS == `TMR_OFF_STATUS;
	wire sel_mask  = AVS_ADDRESS == `TMR_OFF_MASK;
	wire wr_ctrl   = wr_fire & sel_ctrl & AVS_BYTEENABLE[0];
	wire wr_count  = wr_fire & sel_count;
	wire wr_match  = wr_fire & sel_match;
	wire wr_rld    = wr_fire & sel_rld;
	wire wr_stat   = wr_fire & sel_stat & AVS_BYTEENABLE[0];
	wire wr_mask   = wr_fire & sel_mask & AVS_BYTEENABLE[0];

	wire [31:0] rd_mux =
		sel_ctrl  ? {25'h0000000, ctrl_q} :
		sel_count ? {16'h0000, count_q} :
		sel_match ? {16'h0000, match_q} :
		sel_rld   ? {16'h0000, reload_q} :
		sel_stat  ? {30'h00000000, status_q} :
		sel_mask  ? {30'h00000000, mask_q} : 32'h00000000;

	assign AVS_WAITREQUEST = req & ~ack_q;
	assign AVS_READDATA    = rdata_q;

	// control fields
	wire       enable                 = ctrl_q[`TMR_CTRL_EN];
	wire       pwm_mode               = ctrl_q[`TMR_CTRL_MODE] == TMODE_PWM;
	wire [2:0] presc_sel              = ctrl_q[`TMR_CTRL_PRE_HI:`TMR_CTRL_PRE_LO];
	wire       output_polarity_select = ctrl_q[`TMR_CTRL_POL];
	wire       alt_en                 = ctrl_q[`TMR_CTRL_ALT];

	tick_divider u_presc (
		.clk     (CORE_CLK),
		.rst     (RST),
		.run     (enable),
		.div_sel (presc_sel),
		.tick    (tick)
	);

	// count events
	wire tick_en   = enable & tick;
	wire at_reload = count_q == reload_q;
	wire at_match  = count_q == match_q;
	wire reach     = tick_en & at_reload;
	wire match_hit = tick_en & pwm_mode & at_match & ~at_reload;

	assign count_d =
		wr_count ? merge16(count_q, AVS_WRITEDATA, AVS_BYTEENABLE) :
		reach    ? `TMR_COUNT_RESTART :
		tick_en  ? 16'(count_q + 16'h0001) :
		count_q;

	assign ctrl_d =
		wr_ctrl ? AVS_WRITEDATA[`TMR_CTRL_W-1:0] :
		(reach && !pwm_mode) ? (ctrl_q & ~7'h01) :
		ctrl_q;

	// pwm level: polarity at start and reload, inverse after match
	assign level_d =
		!enable   ? output_polarity_select :
		reach     ? output_polarity_select :
		match_hit ? ~output_polarity_select :
		level_q;

	assign out_d =
		!alt_en  ? 1'b0 :
		pwm_mode ? level_d :
		output_polarity_select ^ reach;

	// status: hardware set wins over write-one clear
	assign status_d = (status_q & ~(wr_stat ? AVS_WRITEDATA[`TMR_ST_W-1:0] : 2'b00))
		| {match_hit, reach};

	assign TMR_OUT         = out_q;
	assign TMR_OUT_SEL     = alt_en;
	assign TIMER_IRQ_PULSE = pulse_q;
	assign IRQ             = |(status_q & mask_q);

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			ack_q   <= req & ~ack_q;
			rdata_q <= (AVS_READ && !ack_q) ? rd_mux : rdata_q;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ctrl_q  <= `TMR_CTRL_RST;
			count_q <= `TMR_COUNT_RST;
		end else begin
			ctrl_q  <= ctrl_d;
			count_q <= count_d;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			match_q  <= `TMR_MATCH_RST;
			reload_q <= `TMR_RELOAD_RST;
		end else begin
			match_q  <= wr_match ? merge16(match_q, AVS_WRITEDATA, AVS_BYTEENABLE) : match_q;
			reload_q <= wr_rld ? merge16(reload_q, AVS_WRITEDATA, AVS_BYTEENABLE) : reload_q;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			status_q <= 2'b00;
			mask_q   <= 2'b00;
		end else begin
			status_q <= status_d;
			mask_q   <= wr_mask ? AVS_WRITEDATA[`TMR_ST_W-1:0] : mask_q;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			level_q <= 1'b0;
			out_q   <= 1'b0;
			pulse_q <= 1'b0;
		end else begin
			level_q <= level_d;
			out_q   <= out_d;
			pulse_q <= reach;
		end
	end

	// checks
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	a_count_wrap: assert property (
		(tick_en && count_q == `TMR_COUNT_MAX && reload_q != `TMR_COUNT_MAX && !wr_count)
		|=> count_q == 16'h0000)
		else $error("counter did not wrap to zero");

	a_full_span: assert property (
		(tick_en && reload_q == 16'h0000 && count_q == `TMR_COUNT_MAX && !wr_count)
		|=> (count_q == 16'h0000 && !TIMER_IRQ_PULSE) ##[1:129] (TIMER_IRQ_PULSE || !enable))
		else $error("reload zero not reached after wrap");

	a_oneshot_stop: assert property (
		(reach && !pwm_mode && !wr_ctrl && !wr_count)
		|=> (!enable && count_q == 16'h0001) ##1 (count_q == 16'h0001 || $past(wr_count)))
		else $error("one-shot did not stop at count one");

	a_oneshot_pulse: assert property (
		(reach && !pwm_mode && alt_en && !wr_ctrl)
		|=> (TMR_OUT == ~output_polarity_select) ##1 (TMR_OUT == output_polarity_select || $past(wr_ctrl)))
		else $error("one-shot output pulse not one cycle");

	a_pwm_toggle: assert property (
		(match_hit && alt_en && !wr_ctrl) |=> TMR_OUT == ~output_polarity_select)
		else $error("pwm output not toggled at match");

	a_pwm_continue: assert property (
		(reach && pwm_mode && !wr_ctrl && !wr_count) |=> (enable && count_q == 16'h0001))
		else $error("pwm did not restart at count one");

	a_pwm_restore: assert property (
		(reach && pwm_mode && alt_en && !wr_ctrl) |=> TMR_OUT == output_polarity_select)
		else $error("pwm output not restored at reload");

	a_presc_max: assert property (
		(tick && presc_sel == `TMR_PRE_MAX_SEL && !wr_ctrl) |=> (!tick) [*8])
		else $error("prescale 128 ticked too early");

	a_irq_pulse: assert property (
		TIMER_IRQ_PULSE |-> $past(reach) && ($past(count_q) == $past(reload_q)))
		else $error("irq pulse without reload reach");

	a_irq_sticky: assert property (
		(reach && mask_q[`TMR_ST_RELOAD]) |=> IRQ)
		else $error("masked-in reload event lost");

	a_bus_wait: assert property (
		(req && !ack_q) |-> AVS_WAITREQUEST ##1 (!req || !AVS_WAITREQUEST))
		else $error("bus answer not after one wait state");

	a_count_step: assert property (
		(tick_en && !reach && !wr_count)
		|=> count_q == 16'($past(count_q) + 16'h0001))
		else $error("counter did not advance by one on a tick");

	a_count_hold: assert property (
		(!tick_en && !wr_count)
		|=> count_q == $past(count_q))
		else $error("counter moved without a tick");

	a_oneshot_once: assert property (
		(reach && !pwm_mode && !wr_ctrl)
		|=> !tick_en)
		else $error("one-shot kept counting after reload");

	a_oneshot_level: assert property (
		(alt_en && !pwm_mode && !reach)
		|=> TMR_OUT == $past(output_polarity_select))
		else $error("one-shot output left its resting level");

	a_out_parked: assert property (
		!alt_en
		|=> !TMR_OUT)
		else $error("output driven while alternate function off");

	a_pwm_follow: assert property (
		(alt_en && pwm_mode && $stable(ctrl_q))
		|-> TMR_OUT == level_q)
		else $error("pwm output differs from its level");

	a_pwm_rest: assert property (
		(!enable && $stable(ctrl_q))
		|-> level_q == output_polarity_select)
		else $error("idle pwm level not at polarity");

	a_pulse_follows: assert property (
		reach
		|=> TIMER_IRQ_PULSE)
		else $error("reload reach without irq pulse");

	a_set_wins: assert property (
		(reach && wr_stat && AVS_WRITEDATA[`TMR_ST_RELOAD])
		|=> status_q[`TMR_ST_RELOAD])
		else $error("status clear beat the reload event");

	a_stat_clear: assert property (
		(wr_stat && AVS_WRITEDATA[`TMR_ST_MATCH] && !match_hit)
		|=> !status_q[`TMR_ST_MATCH])
		else $error("match status not cleared by write one");

	a_mask_write: assert property (
		wr_mask
		|=> {30'h00000000, mask_q} == ($past(AVS_WRITEDATA) & 32'h00000003))
		else $error("mask write did not land");

	a_reload_write: assert property (
		(wr_rld && AVS_BYTEENABLE[1:0] == 2'b11)
		|=> {16'h0000, reload_q} == ($past(AVS_WRITEDATA) & 32'h0000ffff))
		else $error("reload write did not land");

	a_read_mask: assert property (
		(AVS_READ && !AVS_WAITREQUEST && sel_mask)
		|-> AVS_READDATA == {30'h00000000, $past(mask_q)})
		else $error("mask read data wrong at completion");

	c_oneshot_done: cover property (reach && !pwm_mode);
	c_pwm_period: cover property (match_hit ##[1:300] reach);
	c_set_over_clear: cover property (wr_stat && reach);
	c_wrap: cover property (tick_en && count_q == `TMR_COUNT_MAX);
	c_presc_max: cover property (tick && presc_sel == `TMR_PRE_MAX_SEL && pwm_mode);

endmodule : timer_oneshot_pwm

// ===== src/timer_pkg.sv
// types shared by the timer files
package timer_pkg;

	typedef enum logic {
		TMODE_ONESHOT,
		TMODE_PWM
	} tmode_e;

	typedef logic [15:0] count_t;

endpackage : timer_pkg

// ===== src/timer_regs.svh
// register offsets, field positions and reset values of the timer
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

`define TMR_ADDR_W        5
`define TMR_OFF_CTRL      5'h00
`define TMR_OFF_COUNT     5'h04
`define TMR_OFF_MATCH     5'h08
`define TMR_OFF_RELOAD    5'h0c
`define TMR_OFF_STATUS    5'h10
`define TMR_OFF_MASK      5'h14

`define TMR_CTRL_EN       0
`define TMR_CTRL_MODE     1
`define TMR_CTRL_PRE_LO   2
`define TMR_CTRL_PRE_HI   4
`define TMR_CTRL_POL      5
`define TMR_CTRL_ALT      6
`define TMR_CTRL_W        7

`define TMR_ST_RELOAD     0
`define TMR_ST_MATCH      1
`define TMR_ST_W          2

`define TMR_CTRL_RST      7'h00
`define TMR_COUNT_RST     16'h0000
`define TMR_MATCH_RST     16'h0000
`define TMR_RELOAD_RST    16'h0000
`define TMR_COUNT_RESTART 16'h0001
`define TMR_COUNT_MAX     16'hffff
`define TMR_PRE_MAX_SEL   3'h7

`endif
